// *** shared/vtrc_map.svh ***
/*
 * Register offsets, field positions, key values and reset values of the
 * vector table relocation and keyed control registers.
 * Assumes byte addresses on an 8-bit register port, one 32-bit word each.
 */
`ifndef VTRC_MAP_SVH
`define VTRC_MAP_SVH

`define VTRC_ADDR_VT        8'h08
`define VTRC_ADDR_CTRL      8'h0C

`define VTRC_VT_REGION_BIT  29
`define VTRC_VT_OFF_HI      28
`define VTRC_VT_OFF_LO      7
`define VTRC_KEY_HI         31
`define VTRC_KEY_LO         16
`define VTRC_ENDIAN_BIT     15
`define VTRC_GRP_HI         10
`define VTRC_GRP_LO         8
`define VTRC_SYSREQ_BIT     2
`define VTRC_CLRACT_BIT     1
`define VTRC_CORERST_BIT    0

`define VTRC_KEY_WRITE      16'h05FA
`define VTRC_KEY_READ       16'hFA05
`define VTRC_CODE_BASE      32'h0000_0000
`define VTRC_SRAM_BASE      32'h2000_0000
`define VTRC_PRIO_KEEP      8'hE0

`define VTRC_RST_REGION     1'h0
`define VTRC_RST_OFFSET     22'h00_0000
`define VTRC_RST_GROUP      3'h0

`endif

// *** shared/vtrc_pkg.sv ***
/*
 * Types shared by the relocation/control block and its priority splitter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package vtrc_pkg;
   typedef logic [2:0] vtrc_group_type;
   typedef logic [7:0] vtrc_prio_type;
   typedef enum {VTRC_SEL_NONE, VTRC_SEL_VT, VTRC_SEL_CTRL} vtrc_sel_type;
endpackage
`default_nettype wire

// *** shared/vtrc_split_if.sv ***
/*
 * Carrier between the control registers and one priority splitter.
 * Assumes the splitter is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface vtrc_split_if;
   import vtrc_pkg::*;
   vtrc_group_type group;
   vtrc_prio_type  prio;
   vtrc_prio_type  preempt;
   vtrc_prio_type  sub;
   modport ctrl  (output group, output prio, input preempt, input sub);
   modport split (input group, input prio, output preempt, output sub);
endinterface
`default_nettype wire

// *** core/vtrc_prio_split.sv ***
/*
 * Splits one 8-bit priority field into pre-emption and subpriority parts.
 * Assumes the grouping value comes from the keyed control register.
 */
`timescale 1ns/1ps
`default_nettype none
module vtrc_prio_split
   import vtrc_pkg::*;
(
   vtrc_split_if.split bus
);
   `include "vtrc_map.svh"

   // ones in bits n..0 for grouping value n
   function automatic vtrc_prio_type sub_mask(input vtrc_group_type n);
      vtrc_prio_type m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (i <= int'(n)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   vtrc_prio_type kept;

   assign kept        = bus.prio & `VTRC_PRIO_KEEP;
   assign bus.sub     = kept & sub_mask(bus.group);
   assign bus.preempt = kept & ~sub_mask(bus.group);
endmodule // vtrc_prio_split
`default_nettype wire

// *** core/vtrc_top.sv ***
/*
 * Vector table relocation register and keyed interrupt/reset control
 * register, with priority grouping applied to a candidate and a running
 * priority. Assumes a one-cycle strobe register port on the core clock
 * and that the chip's warm reset drives nrst_i.
 */
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - region bit 29 picks code space (0) or SRAM space (1) for the table
// - offset bits 28..7 are read/write, relative to the chosen region start
// - control register writes act only with key 0x5FA in bits 31..16
// - control register reads return 0xFA05 in bits 31..16
// - bit 15 reports byte order: 1 big endian, 0 little endian
// - grouping value n gives 7-n pre-emption bits and n+1 subpriority bits
// - arbitration splits each priority into pre-emption and subpriority levels
// - only the upper three priority bits are held
// - writing 1 to clear-active discards all active state, then self-clears
// - writing 1 to core reset resets all but debug, then returns to zero
// - system reset request raises a warm reset request, cleared by that reset
module vtrc_top
   import vtrc_pkg::*;
#(
   parameter logic BIG_ENDIAN = 1'b0
)(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic [7:0]  cand_prio_i,
   input  wire logic [7:0]  run_prio_i,
   output logic      [31:0] vt_base_o,
   output logic      [7:0]  cand_preempt_o,
   output logic      [7:0]  cand_sub_o,
   output logic             preempt_ok_o,
   output logic             clear_active_o,
   output logic             core_reset_o,
   output logic             sys_reset_req_o
);
   `include "vtrc_map.svh"

   function automatic vtrc_sel_type sel_of(input logic [7:0] a);
      if (a == `VTRC_ADDR_VT) begin
         return VTRC_SEL_VT;
      end else if (a == `VTRC_ADDR_CTRL) begin
         return VTRC_SEL_CTRL;
      end
      return VTRC_SEL_NONE;
   endfunction

   logic           vector_table_region_q;
   logic [21:0]    vector_table_offset_q;
   vtrc_group_type priority_split_select_q;
   logic           system_reset_request_q;
   logic           clear_active_state_q;
   logic           core_reset_bit_q;
   logic [31:0]    rdata_q;
   logic [31:0]    rdata_d;
   logic [31:0]    vt_base_q;
   vtrc_prio_type  cand_pre_q;
   vtrc_prio_type  cand_sub_q;
   logic           ok_q;

   vtrc_sel_type   wsel;
   vtrc_sel_type   rsel;
   logic           key_ok;
   logic           vt_wr;
   logic           ctrl_wr;
   logic [31:0]    region_base;

   assign wsel    = sel_of(addr_i);
   assign rsel    = sel_of(addr_i);
   assign key_ok  = wdata_i[`VTRC_KEY_HI:`VTRC_KEY_LO] == `VTRC_KEY_WRITE;
   assign vt_wr   = wr_i && (wsel == VTRC_SEL_VT);
   assign ctrl_wr = wr_i && (wsel == VTRC_SEL_CTRL) && key_ok;

   // relocation register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vector_table_region_q <= `VTRC_RST_REGION;
         vector_table_offset_q <= `VTRC_RST_OFFSET;
      end else if (vt_wr) begin
         vector_table_region_q <= wdata_i[`VTRC_VT_REGION_BIT];
         vector_table_offset_q <= wdata_i[`VTRC_VT_OFF_HI:`VTRC_VT_OFF_LO];
      end
   end

   // grouping field
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         priority_split_select_q <= `VTRC_RST_GROUP;
      end else if (ctrl_wr) begin
         priority_split_select_q <= wdata_i[`VTRC_GRP_HI:`VTRC_GRP_LO];
      end
   end

   // warm reset request holds until the reset it causes
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         system_reset_request_q <= 1'b0;
      end else if (ctrl_wr && wdata_i[`VTRC_SYSREQ_BIT]) begin
         system_reset_request_q <= 1'b1;
      end
   end

   // self-clearing action bits: one-cycle pulses
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clear_active_state_q <= 1'b0;
         core_reset_bit_q     <= 1'b0;
      end else begin
         clear_active_state_q <= ctrl_wr && wdata_i[`VTRC_CLRACT_BIT];
         core_reset_bit_q     <= ctrl_wr && wdata_i[`VTRC_CORERST_BIT];
      end
   end

   // read mux; reserved and action bits read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_i) begin
         unique case (rsel)
            VTRC_SEL_VT: begin
               rdata_d[`VTRC_VT_REGION_BIT]              = vector_table_region_q;
               rdata_d[`VTRC_VT_OFF_HI:`VTRC_VT_OFF_LO]  = vector_table_offset_q;
            end
            VTRC_SEL_CTRL: begin
               rdata_d[`VTRC_KEY_HI:`VTRC_KEY_LO] = `VTRC_KEY_READ;
               rdata_d[`VTRC_ENDIAN_BIT]          = BIG_ENDIAN;
               rdata_d[`VTRC_GRP_HI:`VTRC_GRP_LO] = priority_split_select_q;
               rdata_d[`VTRC_SYSREQ_BIT]          = system_reset_request_q;
            end
            VTRC_SEL_NONE: begin
               rdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // table base address seen by exception entry
   assign region_base = vector_table_region_q ? `VTRC_SRAM_BASE : `VTRC_CODE_BASE;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vt_base_q <= `VTRC_CODE_BASE;
      end else begin
         vt_base_q <= region_base + {3'h0, vector_table_offset_q, 7'h00};
      end
   end

   // index 0: candidate, index 1: running priority
   vtrc_split_if spl [2] ();

   generate
      for (genvar g = 0; g < 2; g++) begin : g_split
         assign spl[g].group = priority_split_select_q;
         assign spl[g].prio  = (g == 0) ? cand_prio_i : run_prio_i;
         vtrc_prio_split u_split (
            .bus (spl[g].split)
         );
      end
   endgenerate

   // lower pre-emption value wins; equal levels never pre-empt
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cand_pre_q <= 8'h00;
         cand_sub_q <= 8'h00;
         ok_q       <= 1'b0;
      end else begin
         cand_pre_q <= spl[0].preempt;
         cand_sub_q <= spl[0].sub;
         ok_q       <= spl[0].preempt < spl[1].preempt;
      end
   end

   assign rdata_o         = rdata_q;
   assign vt_base_o       = vt_base_q;
   assign cand_preempt_o  = cand_pre_q;
   assign cand_sub_o      = cand_sub_q;
   assign preempt_ok_o    = ok_q;
   assign clear_active_o  = clear_active_state_q;
   assign core_reset_o    = core_reset_bit_q;
   assign sys_reset_req_o = system_reset_request_q;

   // checks
   logic first_q;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   chk_reset_zero_fields: assert property (
      first_q |-> vt_base_o == `VTRC_CODE_BASE && priority_split_select_q == 3'h0
   ) else $error("fields not zero after reset");

   chk_region_base_select: assert property (
      vt_wr |=> ##1 vt_base_o[31:29] == ($past(wdata_i[29], 2) ? 3'h1 : 3'h0)
   ) else $error("table region base wrong");

   chk_offset_read_back: assert property (
      vt_wr ##1 (rd_i && addr_i == `VTRC_ADDR_VT)
      |=> rdata_o[28:7] == $past(wdata_i[28:7], 2)
   ) else $error("table offset not read back");

   chk_keyed_write_group: assert property (
      ctrl_wr |=> priority_split_select_q == $past(wdata_i[10:8])
   ) else $error("keyed write did not set grouping");

   chk_bad_key_ignored: assert property (
      (wr_i && addr_i == `VTRC_ADDR_CTRL && !key_ok)
      |=> $stable(priority_split_select_q) && !clear_active_o && !core_reset_o
   ) else $error("write without key changed state");

   chk_key_readback_value: assert property (
      (rd_i && addr_i == `VTRC_ADDR_CTRL) |=> rdata_o[31:16] == 16'hFA05
         && rdata_o[14:11] == 4'h0 && rdata_o[7:3] == 5'h00 && rdata_o[1:0] == 2'h0
   ) else $error("control readback wrong");

   chk_byte_order_flag: assert property (
      (rd_i && addr_i == `VTRC_ADDR_CTRL) |=> rdata_o[15] == BIG_ENDIAN
   ) else $error("byte order flag wrong");

   chk_vt_reserved_zero: assert property (
      (rd_i && addr_i == `VTRC_ADDR_VT) |=> rdata_o[31:30] == 2'h0 && rdata_o[6:0] == 7'h00
   ) else $error("reserved table bits not zero");

   chk_sub_width_split: assert property (
      ##1 (cand_sub_o >> ({1'b0, $past(priority_split_select_q)} + 4'h1)) == 8'h00
   ) else $error("subpriority wider than grouping allows");

   chk_three_bits_kept: assert property (
      !first_q |=> (cand_preempt_o | cand_sub_o) == ($past(cand_prio_i) & 8'hE0)
         && (cand_preempt_o & cand_sub_o) == 8'h00
   ) else $error("priority split does not cover upper three bits");

   chk_preempt_compare: assert property (
      (priority_split_select_q == 3'h7) |=> !preempt_ok_o
   ) else $error("pre-emption with no pre-emption bits");

   chk_clear_active_pulse: assert property (
      (ctrl_wr && wdata_i[1]) |=> clear_active_o ##1 (!clear_active_o || $past(ctrl_wr))
   ) else $error("clear-active not a one-cycle pulse");

   chk_core_reset_pulse: assert property (
      (ctrl_wr && wdata_i[0]) |=> core_reset_o ##1 (!core_reset_o || $past(ctrl_wr))
   ) else $error("core reset not a one-cycle pulse");

   chk_sysreq_held: assert property (
      sys_reset_req_o |=> sys_reset_req_o [*3]
   ) else $error("reset request dropped without reset");

   chk_vt_base_offset: assert property (
      vt_wr |=> ##1 vt_base_o[28:0] == {$past(wdata_i[28:7], 2), 7'h00}
   ) else $error("table base offset wrong");

   chk_region_read_back: assert property (
      vt_wr ##1 (rd_i && addr_i == `VTRC_ADDR_VT)
      |=> rdata_o[29] == $past(wdata_i[29], 2)
   ) else $error("table region bit not read back");

   chk_unmapped_read_zero: assert property (
      (rd_i && addr_i != `VTRC_ADDR_VT && addr_i != `VTRC_ADDR_CTRL) |=> rdata_o == 32'h0000_0000
   ) else $error("unmapped read not zero");

   chk_ctrl_keeps_table: assert property (
      (wr_i && addr_i == `VTRC_ADDR_CTRL)
      |=> $stable(vector_table_offset_q) && $stable(vector_table_region_q)
   ) else $error("control write changed table fields");

   chk_vt_keeps_group: assert property (
      vt_wr |=> $stable(priority_split_select_q) && !clear_active_o && !core_reset_o
   ) else $error("table write changed control fields");

   chk_sysreq_set: assert property (
      (ctrl_wr && wdata_i[`VTRC_SYSREQ_BIT]) |=> sys_reset_req_o
   ) else $error("reset request not raised");

   chk_equal_no_preempt: assert property (
      (cand_prio_i[7:5] == run_prio_i[7:5]) |=> !preempt_ok_o
   ) else $error("equal priority pre-empted");

   cov_keyed_write: cover property (ctrl_wr);
   cov_bad_key: cover property (wr_i && addr_i == `VTRC_ADDR_CTRL && !key_ok);
   cov_sysreq_rise: cover property ($rose(sys_reset_req_o));
   cov_preempt_seen: cover property (preempt_ok_o && priority_split_select_q != 3'h0);
   cov_write_then_read: cover property (vt_wr ##1 (rd_i && addr_i == `VTRC_ADDR_VT));
endmodule // vtrc_top
`default_nettype wire

// *** testbench/tb_vtrc_top.sv ***
/*
 * Self-checking bench for vtrc_top: register port, keyed writes,
 * priority split and action outputs, against an integer model.
 * Assumes the shared package and the core design files compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_vtrc_top;
   import vtrc_pkg::*;
   logic        clk_i;
   logic        nrst_i;
   logic        wr_i;
   logic        rd_i;
   logic [7:0]  addr_i;
   logic [7:0]  cand_prio_i;
   logic [7:0]  run_prio_i;
   logic [31:0] wdata_i;
   logic [31:0] rdata_o;
   logic [31:0] vt_base_o;
   logic [7:0]  cand_preempt_o;
   logic [7:0]  cand_sub_o;
   logic        preempt_ok_o;
   logic        clear_active_o;
   logic        core_reset_o;
   logic        sys_reset_req_o;
   integer      num_errors = 0;
   integer      check_count = 0;
   integer      seed = 32'hD310365A;
   integer      m_vt = 0;
   integer      m_grp = 0;
   integer      m_sys = 0;
   logic [31:0] exp_q [$];
   integer      i;
   logic [31:0] r;
   logic [7:0]  msk;
   logic [7:0]  pc;
   logic [7:0]  pr;

   vtrc_top DUT (
      .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .cand_prio_i, .run_prio_i, .vt_base_o, .cand_preempt_o, .cand_sub_o,
      .preempt_ok_o, .clear_active_o, .core_reset_o, .sys_reset_req_o
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // register model: keyed control fields, table offset masked to its field
   function automatic void model_wr(input logic [7:0] a, input logic [31:0] d);
      if (a == 8'h08) begin
         m_vt = d & 32'h3FFF_FF80;
      end else if (a == 8'h0C && d[31:16] == 16'h05FA) begin
         m_grp = int'(d[10:8]);
         if (d[2]) begin
            m_sys = 1;
         end
      end
   endfunction

   function automatic logic [31:0] model_rd(input logic [7:0] a);
      if (a == 8'h08) begin
         return m_vt;
      end else if (a == 8'h0C) begin
         return 32'hFA05_0000 | (m_grp << 8) | (m_sys << 2);
      end
      return 32'h0000_0000;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      model_wr(a, d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(negedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a);
      exp_q.push_back(model_rd(a));
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o, exp_q.pop_front());
   endtask

   // write then read the same word with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
      model_wr(a, d);
      exp_q.push_back(model_rd(a));
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o, exp_q.pop_front());
   endtask

   // random priorities, model split on the upper three bits
   task automatic split(input integer g);
      @(posedge clk_i);
      pc = 8'($random(seed));
      pr = 8'($random(seed));
      cand_prio_i <= pc;
      run_prio_i <= pr;
      msk = 8'hFF << (g + 1);
      @(posedge clk_i);
      @(negedge clk_i);
      chk(cand_preempt_o, pc & 8'hE0 & msk);
      chk(cand_sub_o, pc & 8'hE0 & ~msk);
      chk(preempt_ok_o, (pc & 8'hE0 & msk) < (pr & 8'hE0 & msk));
   endtask

   task automatic wrap_up;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   initial begin
      #300000;
      num_errors++;
      wrap_up;
   end

   initial begin
      nrst_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      cand_prio_i = 8'h00;
      run_prio_i = 8'h00;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      rd(8'h08);
      rd(8'h0C);
      chk(vt_base_o, 32'h0);
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         wr(8'h08, r);
         @(negedge clk_i);
         chk(vt_base_o, (r[29] ? 32'h2000_0000 : 32'h0) + (r & 32'h1FFF_FF80));
         rd(8'h08);
         r = $random(seed);
         wr_rd(8'h08, r);
      end
      // unmapped address: write lost, read zero
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10);
      rd(8'h08);
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         wr(8'h0C, {16'h05FA, r[15:11], i[2:0], r[7:3], 3'h0});
         rd(8'h0C);
         repeat (4) split(m_grp);
      end
      // wrong keys, the read pattern among them
      wr(8'h0C, 32'hFA05_0302);
      chk(clear_active_o, 1'b0);
      wr(8'h0C, 32'h05FB_0001);
      chk(core_reset_o, 1'b0);
      rd(8'h0C);
      wr(8'h0C, 32'h05FA_0702);
      chk(clear_active_o, 1'b1);
      chk(core_reset_o, 1'b0);
      @(negedge clk_i);
      chk(clear_active_o, 1'b0);
      wr(8'h0C, 32'h05FA_0701);
      chk(core_reset_o, 1'b1);
      @(negedge clk_i);
      chk(core_reset_o, 1'b0);
      rd(8'h0C);
      wr(8'h0C, 32'h05FA_0704);
      chk(sys_reset_req_o, 1'b1);
      wr(8'h0C, 32'h05FA_0700);
      rd(8'h0C);
      chk(sys_reset_req_o, 1'b1);
      // warm reset in mid-run
      @(posedge clk_i);
      nrst_i <= 1'b0;
      m_vt = 0;
      m_grp = 0;
      m_sys = 0;
      @(negedge clk_i);
      chk(sys_reset_req_o, 1'b0);
      chk(vt_base_o, 32'h0);
      @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      rd(8'h0C);
      rd(8'h08);
      wrap_up;
   end
endmodule // tb_vtrc_top
`default_nettype wire
